// ### design/pwm_timer_pkg.sv
package pwm_timer_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CMP0 = 8'h08;
  localparam logic [7:0] OFF_CMP1 = 8'h0c;
  localparam logic [7:0] OFF_CMP2 = 8'h10;
  localparam logic [7:0] OFF_CMP3 = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;

  // field positions
  localparam int EN_BIT = 0;
  localparam int SOFT_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int EDGE_LSB = 4;
  localparam int ST_RUN_LSB = 0;
  localparam int ST_ARMED_BIT = 2;
  localparam int ST_OUT_LSB = 4;

  // mode_select_field encodings served here
  localparam logic [2:0] MODE_TRIG_PWM = 3'h2;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h3;

  // counter values and reset values
  localparam logic [15:0] CNT_IDLE = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] EDGE_RST = 2'h1;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } run_e;

  // edge_sel: bit0 rising, bit1 falling
  typedef struct packed {
    logic [1:0] edge_sel;
    logic [2:0] mode;
    logic en;
  } ctrl_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } apb_resp_s;

  typedef struct packed {
    apb_resp_s resp;
    ctrl_s ctrl;
    logic [2:0] sync;
    logic soft_pend;
    logic soft_src;
    logic armed;
    run_e run;
    logic [15:0] cnt;
    logic [3:0][15:0] cmp;
    logic [3:0][15:0] sh;
    logic [3:0] out;
    logic [3:0] irq;
  } timer_s;

endpackage

// ### design/triggered_pwm_oneshot_timer.sv
`timescale 1ns/1ps
// Overview of operation
// - pwm shadow transfer armed only by cmp1 write
// - armed copy happens when counter clears
// - compare zero keeps pwm channel inactive
// - zero compare still interrupts every period not begun by a pwm trigger
// - compare period plus one gives full duty
// - trigger after channel match reasserts output
// - trigger before channel match suppresses irq
// - trigger after period match restarts count
// - trigger before period match suppresses irq
// - channel irq coincides with counter match
// - one-shot mode waits for trigger
// - one-shot trigger clears counter, starts pulse
// - pulse end reloads ffff and stops
// - triggers ignored while pulse runs
// - delay compare, width period minus compare plus one
// - period irq after match, channel irq on match
// - external edge or soft bit triggers
// - channel0 shows one-shot running under soft trigger
// - pwm trigger clears and restarts counter
// - pwm period plus one, width compare
module triggered_pwm_oneshot_timer
  import pwm_timer_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic ext_trigger,
  output logic [3:0] channel_output,
  output logic period_match_irq,
  output logic [3:1] channel_match_irq
);

  timer_s st_q;
  timer_s st_d;

  logic setup;
  logic wr;
  logic wr_cmp1;
  logic mapped;
  logic [31:0] rd_val;
  logic pwm_m;
  logic one_m;
  logic active;
  logic ext_edge;
  logic trig;
  logic restart;
  logic wrap;
  logic os_start;
  logic os_end;
  logic load;
  logic [15:0] cnt_nx;
  run_e st_nx;
  logic [3:0][15:0] sh_nx;
  logic [3:1] hit;
  logic [3:1] out_nx;
  logic [3:1] irq_nx;

  // apb: zero wait states, answer registered during setup
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & st_q.resp.ready;
  assign wr_cmp1 = wr & (paddr == OFF_CMP1);

  always_comb begin
    mapped = 1'b1;
    rd_val = RDATA_RST;
    case (paddr)
      OFF_CTRL0: rd_val[EN_BIT] = st_q.ctrl.en;
      OFF_CTRL1: begin
        rd_val[MODE_LSB +: 3] = st_q.ctrl.mode;
        rd_val[EDGE_LSB +: 2] = st_q.ctrl.edge_sel;
      end
      OFF_CMP0: rd_val[15:0] = st_q.cmp[0];
      OFF_CMP1: rd_val[15:0] = st_q.cmp[1];
      OFF_CMP2: rd_val[15:0] = st_q.cmp[2];
      OFF_CMP3: rd_val[15:0] = st_q.cmp[3];
      OFF_COUNT: rd_val[15:0] = st_q.cnt;
      OFF_STATUS: begin
        rd_val[ST_RUN_LSB +: 2] = st_q.run;
        rd_val[ST_ARMED_BIT] = st_q.armed;
        rd_val[ST_OUT_LSB +: 4] = st_q.out;
      end
      default: mapped = 1'b0;
    endcase
  end

  // mode and trigger decode
  assign pwm_m = st_q.ctrl.en && (st_q.ctrl.mode == MODE_TRIG_PWM);
  assign one_m = st_q.ctrl.en && (st_q.ctrl.mode == MODE_ONE_SHOT);
  assign active = pwm_m | one_m;
  // sync[1] is the second stage, sync[2] the previous sample of it
  assign ext_edge = (st_q.ctrl.edge_sel[0] & st_q.sync[1] & ~st_q.sync[2]) |
                    (st_q.ctrl.edge_sel[1] & ~st_q.sync[1] & st_q.sync[2]);
  assign trig = ext_edge | st_q.soft_pend;

  // a trigger in wait or run restarts the pwm count
  assign restart = pwm_m && (st_q.run != ST_IDLE) && trig;
  // period match loses to a trigger in the same cycle
  assign wrap = pwm_m && (st_q.run == ST_RUN) && (st_q.cnt == st_q.sh[0]) && !trig;
  assign os_start = one_m && (st_q.run == ST_WAIT) && trig;
  assign os_end = one_m && (st_q.run == ST_RUN) && (st_q.cnt == st_q.sh[0]);
  assign load = (restart | wrap) && st_q.armed;

  // outside pwm the compare values act at once
  assign sh_nx = (!pwm_m || load) ? st_q.cmp : st_q.sh;

  assign cnt_nx = !active ? CNT_IDLE :
                  (restart | wrap | os_start) ? CNT_ZERO :
                  os_end ? CNT_IDLE :
                  (st_q.run == ST_RUN) ? 16'(st_q.cnt + CNT_STEP) : st_q.cnt;

  assign st_nx = !active ? ST_IDLE :
                 (restart | os_start) ? ST_RUN :
                 os_end ? ST_WAIT :
                 (st_q.run == ST_IDLE) ? ST_WAIT : st_q.run;

  // per channel compare, output and interrupt
  for (genvar k = 1; k <= 3; k++) begin : g_chan
    assign hit[k] = (st_nx == ST_RUN) && (cnt_nx == sh_nx[k]);
    // a pwm trigger hides the channel match it lands on
    assign irq_nx[k] = hit[k] && !(pwm_m && trig);
    // pwm: match ends the active part, clear starts it; zero wins
    // one-shot: match starts the pulse, period match ends it
    assign out_nx[k] = !active ? 1'b0 :
                       pwm_m ? (hit[k] ? 1'b0 : ((restart | wrap) ? 1'b1 : st_q.out[k])) :
                       (hit[k] ? 1'b1 : (os_end ? 1'b0 : st_q.out[k]));
  end

  always_comb begin
    st_d = st_q;
    // apb answer
    st_d.resp.ready = setup;
    st_d.resp.slverr = setup & ~mapped;
    st_d.resp.rdata = setup ? rd_val : st_q.resp.rdata;
    st_d.soft_pend = 1'b0;
    if (wr) begin
      case (paddr)
        OFF_CTRL0: st_d.ctrl.en = pwdata[EN_BIT];
        OFF_CTRL1: begin
          st_d.ctrl.mode = pwdata[MODE_LSB +: 3];
          st_d.ctrl.edge_sel = pwdata[EDGE_LSB +: 2];
          st_d.soft_pend = pwdata[SOFT_BIT];
        end
        OFF_CMP0: st_d.cmp[0] = pwdata[15:0];
        OFF_CMP1: st_d.cmp[1] = pwdata[15:0];
        OFF_CMP2: st_d.cmp[2] = pwdata[15:0];
        OFF_CMP3: st_d.cmp[3] = pwdata[15:0];
        default: st_d.cmp = st_q.cmp;
      endcase
    end
    // trigger pin synchroniser and edge history
    st_d.sync = {st_q.sync[1], st_q.sync[0], ext_trigger};
    // a write in the clearing cycle re-arms, so set wins over clear
    st_d.armed = (st_q.armed & ~load) | wr_cmp1;
    st_d.run = st_nx;
    st_d.cnt = cnt_nx;
    st_d.sh = sh_nx;
    st_d.soft_src = os_start ? st_q.soft_pend : st_q.soft_src;
    st_d.irq = {irq_nx, wrap | os_end};
    st_d.out[3:1] = out_nx;
    if (!active) begin
      st_d.out[0] = 1'b0;
    end else if (pwm_m) begin
      st_d.out[0] = (restart | wrap) ? ~st_q.out[0] : st_q.out[0];
    end else begin
      st_d.out[0] = (st_nx == ST_RUN) && (os_start ? st_q.soft_pend : st_q.soft_src);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.resp <= '{rdata: RDATA_RST, ready: 1'b0, slverr: 1'b0};
      st_q.ctrl <= '{edge_sel: EDGE_RST, mode: MODE_RST, en: 1'b0};
      st_q.sync <= 3'h0;
      st_q.soft_pend <= 1'b0;
      st_q.soft_src <= 1'b0;
      st_q.armed <= 1'b0;
      st_q.run <= ST_IDLE;
      st_q.cnt <= CNT_IDLE;
      st_q.cmp <= {4{CMP_RST}};
      st_q.sh <= {4{CMP_RST}};
      st_q.out <= 4'h0;
      st_q.irq <= 4'h0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.resp.rdata;
  assign pready = st_q.resp.ready;
  assign pslverr = st_q.resp.slverr;
  assign channel_output = st_q.out;
  assign period_match_irq = st_q.irq[0];
  assign channel_match_irq = st_q.irq[3:1];

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic pwm_run;
  logic one_run;
  assign pwm_run = pwm_m && (st_q.run == ST_RUN);
  assign one_run = one_m && (st_q.run == ST_RUN);

  shadow_hold_a: assert property ((pwm_run && !st_q.armed && !wr) |=> $stable(st_q.sh))
    else $error("shadow changed without cmp1 write");
  shadow_load_a: assert property ((wrap && st_q.armed && !wr) |=> (st_q.sh == $past(st_q.cmp)) && !st_q.armed)
    else $error("armed shadow not loaded at period clear");
  zero_duty_a: assert property ((pwm_run && (st_q.sh[1] == CNT_ZERO)) |-> !channel_output[1])
    else $error("zero compare drove channel active");
  zero_irq_a: assert property ((wrap && (st_q.sh[0] == CNT_IDLE) && (st_q.sh[1] == CNT_ZERO) && !st_q.armed)
                               |=> channel_match_irq[1] && period_match_irq)
    else $error("zero compare missed its period irq");
  full_duty_a: assert property ((pwm_run && !wr && !st_q.armed && channel_output[3] && (st_q.sh[0] != CNT_IDLE) &&
                                 (st_q.sh[3] == 16'(st_q.sh[0] + CNT_STEP))) |=> channel_output[3])
    else $error("full duty output dropped");
  trig_restart_a: assert property ((restart && !wr) |=> (st_q.cnt == CNT_ZERO) && !period_match_irq &&
                                   (channel_output[1] == (st_q.sh[1] != CNT_ZERO)))
    else $error("pwm trigger did not restart cleanly");
  pwm_wrap_a: assert property ((wrap && !wr) |=> period_match_irq && (st_q.cnt == CNT_ZERO))
    else $error("period match did not clear counter");
  chan_irq_a: assert property (channel_match_irq[1] |-> (st_q.cnt == st_q.sh[1]) && (st_q.run == ST_RUN))
    else $error("channel irq not aligned with match");
  os_start_a: assert property ((os_start && !wr) |=> (st_q.run == ST_RUN) && (st_q.cnt == CNT_ZERO))
    else $error("one-shot did not start on trigger");
  os_end_a: assert property ((os_end && !wr) |=> period_match_irq && (st_q.cnt == CNT_IDLE) &&
                             (st_q.run == ST_WAIT) && !channel_output[1])
    else $error("one-shot did not stop at period match");
  os_ignore_a: assert property ((one_run && trig && (st_q.cnt != st_q.sh[0]) && !wr) |=>
                                (st_q.cnt == 16'($past(st_q.cnt) + CNT_STEP)))
    else $error("trigger disturbed a running one-shot");
  os_delay_a: assert property ((one_m && $rose(channel_output[1])) |-> (st_q.cnt == st_q.sh[1]))
    else $error("one-shot pulse began off its compare");
  soft_level_a: assert property ((one_m && !$past(wr)) |-> channel_output[0] == ((st_q.run == ST_RUN) && st_q.soft_src))
    else $error("channel0 not tracking soft one-shot run");
  edge_take_a: assert property ((one_m && (st_q.run == ST_WAIT) && st_q.ctrl.edge_sel[0] && st_q.sync[1] &&
                                 !st_q.sync[2] && !wr) |=> (st_q.run == ST_RUN))
    else $error("rising trigger edge missed");


  ready_after_setup_a: assert property ((psel && !penable)
    |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready
    |=> !pready)
    else $error("pready held longer than one cycle");
  ready_idle_a: assert property (!psel
    |=> !pready)
    else $error("pready without a transfer");
  err_ready_a: assert property (pslverr
    |-> pready)
    else $error("pslverr without pready");
  err_unmapped_a: assert property ((setup && !mapped)
    |=> pslverr && (prdata == RDATA_RST))
    else $error("unmapped access not refused");
  err_mapped_a: assert property ((setup && mapped)
    |=> !pslverr)
    else $error("mapped access flagged as error");
  rdata_hold_a: assert property (!setup
    |=> $stable(prdata))
    else $error("read data moved outside setup");
  count_read_a: assert property ((setup && (paddr == OFF_COUNT))
    |=> (prdata == {16'h0000, $past(st_q.cnt)}))
    else $error("counter read mismatch");
  en_write_a: assert property ((wr && (paddr == OFF_CTRL0))
    |=> (st_q.ctrl.en == $past(pwdata[EN_BIT])))
    else $error("enable write lost");
  cmp2_write_a: assert property ((wr && (paddr == OFF_CMP2))
    |=> (st_q.cmp[2] == $past(pwdata[15:0])))
    else $error("compare write lost");
  cmp_keep_a: assert property (!wr
    |=> $stable(st_q.cmp))
    else $error("compare changed without a write");
  soft_pulse_a: assert property (st_q.soft_pend
    |=> !st_q.soft_pend)
    else $error("soft trigger lasted more than one cycle");

  arm_set_a: assert property (wr_cmp1
    |=> st_q.armed)
    else $error("cmp1 write did not arm transfer");
  arm_clear_a: assert property ((load && !wr_cmp1)
    |=> !st_q.armed)
    else $error("armed flag survived its transfer");
  arm_hold_a: assert property ((!load && !wr_cmp1)
    |=> $stable(st_q.armed))
    else $error("armed flag moved on its own");
  shadow_follow_a: assert property (!pwm_m
    |=> (st_q.sh == $past(st_q.cmp)))
    else $error("shadow not following compare outside pwm");
  restart_load_a: assert property ((restart && st_q.armed)
    |=> (st_q.sh == $past(st_q.cmp)))
    else $error("armed shadow not loaded at trigger clear");

  idle_quiet_a: assert property (!active
    |=> (channel_output == 4'h0) && !period_match_irq && (channel_match_irq == 3'h0) && (st_q.cnt == CNT_IDLE))
    else $error("disabled timer not quiet");
  idle_to_wait_a: assert property ((active && (st_q.run == ST_IDLE))
    |=> (st_q.run == ST_WAIT))
    else $error("enable did not enter wait");
  wait_idle_cnt_a: assert property ((active && (st_q.run == ST_WAIT))
    |-> (st_q.cnt == CNT_IDLE) && (channel_output == 4'h0))
    else $error("waiting timer not parked");
  wait_hold_a: assert property ((active && (st_q.run == ST_WAIT) && !trig)
    |=> (st_q.run == ST_WAIT) && $stable(st_q.cnt))
    else $error("wait left without a trigger");

  pwm_soft_start_a: assert property ((pwm_m && (st_q.run == ST_WAIT) && st_q.soft_pend)
    |=> (st_q.run == ST_RUN) && (st_q.cnt == CNT_ZERO))
    else $error("soft trigger did not start pwm");
  pwm_stay_a: assert property (pwm_run
    |=> (st_q.run == ST_RUN))
    else $error("pwm left run state");
  pwm_count_a: assert property ((pwm_run && !trig && (st_q.cnt != st_q.sh[0]))
    |=> (st_q.cnt == 16'($past(st_q.cnt) + CNT_STEP)))
    else $error("pwm counter skipped");
  pwm_hide_a: assert property ((pwm_run && trig && (st_q.cnt == st_q.sh[0]))
    |=> !period_match_irq)
    else $error("period irq not hidden by trigger");
  ch0_toggle_a: assert property ((pwm_m && (restart || wrap))
    |=> (channel_output[0] != $past(channel_output[0])))
    else $error("channel0 did not toggle on clear");
  pwm_drop1_a: assert property ((pwm_m && hit[1])
    |=> !channel_output[1])
    else $error("channel1 stayed active past match");
  pwm_drop2_a: assert property ((pwm_m && hit[2])
    |=> !channel_output[2])
    else $error("channel2 stayed active past match");
  pwm_drop3_a: assert property ((pwm_m && hit[3])
    |=> !channel_output[3])
    else $error("channel3 stayed active past match");
  pwm_hide_chan_a: assert property ((pwm_m && trig && hit[1])
    |=> !channel_match_irq[1])
    else $error("channel irq not hidden by trigger");
  zero_duty2_a: assert property ((pwm_run && (st_q.sh[2] == CNT_ZERO))
    |-> !channel_output[2])
    else $error("zero compare drove channel2 active");
  chan2_irq_a: assert property (channel_match_irq[2]
    |-> (st_q.cnt == st_q.sh[2]) && (st_q.run == ST_RUN))
    else $error("channel2 irq not aligned with match");
  chan3_irq_a: assert property (channel_match_irq[3]
    |-> (st_q.cnt == st_q.sh[3]) && (st_q.run == ST_RUN))
    else $error("channel3 irq not aligned with match");

  os_pulse1_a: assert property ((one_m && hit[1])
    |=> channel_output[1] && channel_match_irq[1])
    else $error("one-shot match did not start pulse");
  os_end_rest_a: assert property (os_end
    |=> (channel_output[3:2] == 2'h0) && !channel_output[0])
    else $error("one-shot end left outputs active");
  os_soft_ch0_a: assert property ((os_start && st_q.soft_pend)
    |=> channel_output[0])
    else $error("channel0 idle under soft one-shot");
  os_ext_ch0_a: assert property ((os_start && !st_q.soft_pend)
    |=> !channel_output[0])
    else $error("channel0 active under pin one-shot");
  os_run_stay_a: assert property ((one_run && (st_q.cnt != st_q.sh[0]))
    |=> (st_q.run == ST_RUN))
    else $error("one-shot stopped early");
  edge_fall_a: assert property ((one_m && (st_q.run == ST_WAIT) && st_q.ctrl.edge_sel[1] && !st_q.sync[1] &&
    st_q.sync[2]) |=> (st_q.run == ST_RUN))
    else $error("falling trigger edge missed");

  load_cov_c: cover property (wrap && st_q.armed);
  restart_cov_c: cover property (pwm_run && trig);
  os_done_c: cover property (os_end ##1 (st_q.run == ST_WAIT));
  soft_os_c: cover property (one_run && channel_output[0]);
  trig_hide_c: cover property (pwm_run && trig && (st_q.cnt == st_q.sh[0]));

endmodule // triggered_pwm_oneshot_timer

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pwm_timer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, period_match_irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] channel_output;
  logic [3:1] channel_match_irq;
  wire ext_trigger;
  logic [7:0] samp [0:39];
  int fails = 0, comparisons = 0, cyc = 0, f;

  triggered_pwm_oneshot_timer u_triggered_pwm_oneshot_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trigger(ext_trigger), .channel_output(channel_output),
    .period_match_irq(period_match_irq), .channel_match_irq(channel_match_irq));
  trigger_source u_trigger_source (.pclk(pclk), .ext_trigger(ext_trigger));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic print_verdict();
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // a hung handshake ends here instead of running forever
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look between edges so the registered pready is read settled, not racing its own edge
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // bits 3:0 outputs, 4 period irq, 7:5 channel irqs
  task automatic rec();
    for (int i = 0; i < 40; i++) begin
      @(negedge pclk);
      samp[i] = {channel_match_irq, period_match_irq, channel_output};
    end
  endtask

  function automatic int cnt(int b);
    int n = 0;
    for (int i = 0; i < 40; i++) n += (samp[i][b] === 1'b1);
    return n;
  endfunction

  function automatic int nxt(int b, int s);
    for (int i = s; i < 40; i++) if (samp[i][b] === 1'b1) return i;
    return 99;
  endfunction

  task automatic t_regs();
    apb(1'b0, OFF_CMP0, 32'h0);
    chk("cmp0_reset", 32'(CMP_RST), rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
  endtask

  task automatic t_oneshot_soft();
    apb(1'b1, OFF_CMP0, 32'h5);
    apb(1'b1, OFF_CMP2, 32'h0);
    apb(1'b1, OFF_CMP3, 32'h6);
    apb(1'b1, OFF_CMP1, 32'h2);
    apb(1'b1, OFF_CTRL1, 32'h16);
    apb(1'b1, OFF_CTRL0, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("wait_state", 32'h1, 32'(rd[1:0]));
    fork
      apb(1'b1, OFF_CTRL1, 32'h17);
      rec();
    join
    f = nxt(0, 0);
    chk("delay1", 32'h2, 32'(nxt(1, 0) - f));
    chk("width1", 32'h4, 32'(cnt(1)));
    chk("width2", 32'h6, 32'(cnt(2)));
    chk("no_pulse3", 32'h0, 32'(cnt(3)));
    chk("run_ch0", 32'h6, 32'(cnt(0)));
    chk("irq1_at_rise", 32'(nxt(1, 0)), 32'(nxt(5, 0)));
    chk("period_irq", 32'(f + 6), 32'(nxt(4, 0)));
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("reload", 32'(CNT_IDLE), rd);
  endtask

  // second edge lands while the pulse still runs
  task automatic t_oneshot_ext();
    fork
      begin
        u_trigger_source.fire();
        u_trigger_source.fire();
      end
      rec();
    join
    chk("ext_width1", 32'h4, 32'(cnt(1)));
    chk("ext_ch0", 32'h0, 32'(cnt(0)));
  endtask

  task automatic t_pwm();
    apb(1'b1, OFF_CTRL0, 32'h0);
    apb(1'b1, OFF_CTRL1, 32'h14);
    apb(1'b1, OFF_CMP0, 32'h3);
    apb(1'b1, OFF_CMP2, 32'h0);
    apb(1'b1, OFF_CMP3, 32'h4);
    apb(1'b1, OFF_CMP1, 32'h1);
    apb(1'b1, OFF_CTRL0, 32'h1);
    apb(1'b1, OFF_CTRL1, 32'h15);
    rec();
    f = nxt(4, 0);
    chk("pwm_period", 32'(f + 4), 32'(nxt(4, f + 1)));
    chk("out1_at_clear", 32'h1, 32'(samp[f][1]));
    chk("out1_drop", 32'h0, 32'(samp[f + 1][1]));
    chk("irq1_on_match", 32'h1, 32'(samp[f + 1][5]));
    chk("zero_duty", 32'h0, 32'(cnt(2)));
    chk("full_duty", 32'h1, 32'(samp[f + 2][3] & samp[f + 3][3]));
    apb(1'b1, OFF_CMP0, 32'h5);
    rec();
    f = nxt(4, 0);
    chk("no_arm", 32'(f + 4), 32'(nxt(4, f + 1)));
    apb(1'b1, OFF_CMP1, 32'h1);
    rec();
    f = nxt(4, 0);
    chk("reloaded", 32'(f + 6), 32'(nxt(4, f + 1)));
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_oneshot_soft();
    t_oneshot_ext();
    t_pwm();
    print_verdict();
  end
endmodule // tb_top

// ### tb/trigger_source.sv
`timescale 1ns/1ps
module trigger_source (
  // clock
  input wire logic pclk,
  // trigger pin
  output logic ext_trigger
);
  // idle low between pulses so a stale level never looks like a new edge
  initial ext_trigger = 1'b0;

  // one rising edge, held two clocks so the two-flop sampler cannot miss it
  task automatic fire();
    ext_trigger <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_trigger <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule // trigger_source
